// file: rtl/twt_pkg.sv
// twt_pkg: constants, states and carriers of the two-wire target block
// assumes: one 25 MHz core clock, byte-wide register port
package twt_pkg;

	// register offsets on the plain register port
	localparam logic [7:0] OFF_CTRL_A = 8'h09;
	localparam logic [7:0] OFF_CTRL_B = 8'h0a;
	localparam logic [7:0] OFF_STATUS = 8'h0b;
	localparam logic [7:0] OFF_OWN    = 8'h0c;
	localparam logic [7:0] OFF_DATA   = 8'h0d;
	localparam logic [7:0] OFF_SECOND = 8'h0e;

	// reset values
	localparam logic [7:0] RST_BYTE   = 8'h00;

	// control a fields
	localparam int CA_ENABLE   = 0;
	localparam int CA_PROMISC  = 2;
	localparam int CA_STOP_EN  = 5;

	// control b fields
	localparam int CB_ACK      = 2;
	localparam logic [1:0] CMD_NONE = 2'h0;
	localparam logic [1:0] CMD_COMP = 2'h2;
	localparam logic [1:0] CMD_RESP = 2'h3;

	// status fields
	localparam int ST_DATA     = 7;
	localparam int ST_MATCH    = 6;
	localparam int ST_STRETCH  = 5;
	localparam int ST_RXACK    = 4;
	localparam int ST_CLASH    = 3;
	localparam int ST_FAULT    = 2;
	localparam int ST_DIR      = 1;
	localparam int ST_CAUSE    = 0;

	// bit counting
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] BIT_ZERO      = 4'h0;
	localparam logic [3:0] BIT_ONE       = 4'h1;

	// link state machine
	typedef enum logic [2:0] {
		LS_IDLE,
		LS_ADDR,
		LS_HOLD,
		LS_ACK_OUT,
		LS_RX,
		LS_TX,
		LS_ACK_IN
	} twt_link_e;

	// what follows an acknowledge bit sent by the target
	typedef enum logic [1:0] {
		PA_RX,
		PA_DATA_EVT,
		PA_IDLE
	} twt_post_e;

	// one register port request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} twt_req_s;

endpackage : twt_pkg

// file: rtl/twt_target.sv
// twt_target: target side of a two-wire serial link with address match,
// status flags and shift data register reached over a plain register port
// assumes: scl/sda are open-drain wires resolved outside; core clock at
// least four times the scl rate; controller enable comes on core clock
//
// Behaviour
// - tx clash set when target leaves sda high for data/nack and sees low
// - while clash is set the target never pulls sda low
// - data done flag still sets at the end of a clashed byte
// - clash on an address nack comes after the trigger has cleared the match flag
// - clash clears by writing one or on any start condition
// - bus fault set on misplaced start, repeated start or stop
// - writing one to bus fault bit clears it
// - bus fault detection needs controller enable and fast core clock
// - direction bit holds r/w bit of last matched address
// - cause bit reads 0 for stop, 1 for address match
// - own address bits 7:1 are the address, bit 0 enables general call
// - match flag sets when received address passes the match logic
// - ten-bit mode matches only the first byte 11110aa
// - data register is the shift register; writes blocked while shifting
// - data register access succeeds only while clock is held
// - data access during clock hold starts the next bus operation
// - dual select zero: second register bits 7:1 mask own address bits
// - dual select one: second register is another target address
// - acknowledge choice applied on data access or execute command
// - clock stretch holds scl low while a data or address match event waits
// - promiscuous match accepts every address
`timescale 1ns/1ns
module twt_target
(
	// clock and reset
	input  wire logic              core_clk,
	input  wire logic              rst_n,
	// register port
	input  wire twt_pkg::twt_req_s req,
	output logic [7:0]             rdata,
	// controller side enable
	input  wire logic              ctrl_a_enable,
	// two-wire pins
	input  wire logic              scl_in,
	output logic                   scl_out,
	output logic                   scl_oe,
	input  wire logic              sda_in,
	output logic                   sda_out,
	output logic                   sda_oe,
	// event lines to the rest of the unit
	output logic                   data_done_flag,
	output logic                   match_or_halt_flag,
	output logic                   scl_stretch_status
);

	// pin synchronisers and history
	logic              scl_meta_ff;
	logic              scl_s_ff;
	logic              scl_prev_ff;
	logic              sda_meta_ff;
	logic              sda_s_ff;
	logic              sda_prev_ff;
	// link state
	twt_pkg::twt_link_e state_ff;
	twt_pkg::twt_link_e nxt_state;
	twt_pkg::twt_post_e post_ff;
	twt_pkg::twt_post_e nxt_post;
	logic [3:0]        bitcnt_ff;
	logic [3:0]        nxt_bitcnt;
	logic [7:0]        shift_ff;
	logic [7:0]        nxt_shift;
	logic              ack_sent_ff;
	logic              nxt_ack_sent;
	logic              sda_oe_ff;
	logic              scl_oe_ff;
	// registers
	logic [7:0]        ctrl_a_ff;
	logic              ack_choice_ff;
	logic [7:0]        own_ff;
	logic [7:0]        second_ff;
	logic [7:0]        rdata_ff;
	// flags
	logic              data_ff;
	logic              match_ff;
	logic              cause_ff;
	logic              clash_ff;
	logic              fault_ff;
	logic              dir_ff;
	logic              rxack_ff;
	// events from the link logic
	logic              set_data;
	logic              set_match;
	logic              set_cause;
	logic              set_clash;
	logic              set_fault;
	logic              set_dir;
	logic              set_rxack;

	// decoded access strobes
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	logic wr_ctrl_b;
	logic wr_status;
	logic holding;
	logic data_acc;
	logic cmd_valid;
	logic trig;
	logic eff_ack;
	logic evt_clr;
	logic mid_byte;
	logic addr_hit;

	// two flops on each pin before any logic looks at it
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			scl_meta_ff <= 1'b1;
			scl_s_ff    <= 1'b1;
			scl_prev_ff <= 1'b1;
			sda_meta_ff <= 1'b1;
			sda_s_ff    <= 1'b1;
			sda_prev_ff <= 1'b1;
		end
		else
		begin
			scl_meta_ff <= scl_in;
			scl_s_ff    <= scl_meta_ff;
			scl_prev_ff <= scl_s_ff;
			sda_meta_ff <= sda_in;
			sda_s_ff    <= sda_meta_ff;
			sda_prev_ff <= sda_s_ff;
		end
	end

	// bus conditions; sda moving while scl is high marks start or stop
	assign scl_rise  = scl_s_ff & ~scl_prev_ff;
	assign scl_fall  = ~scl_s_ff & scl_prev_ff;
	assign start_det = scl_s_ff & scl_prev_ff & sda_prev_ff & ~sda_s_ff;
	assign stop_det  = scl_s_ff & scl_prev_ff & ~sda_prev_ff & sda_s_ff;

	// register port decode
	assign wr_ctrl_b = req.wr && (req.addr == twt_pkg::OFF_CTRL_B);
	assign wr_status = req.wr && (req.addr == twt_pkg::OFF_STATUS);
	assign holding   = (state_ff == twt_pkg::LS_HOLD);
	assign data_acc  = (req.wr || req.rd) && (req.addr == twt_pkg::OFF_DATA)
		&& holding;
	assign cmd_valid = wr_ctrl_b
		&& ((req.wdata[1:0] == twt_pkg::CMD_COMP)
		|| (req.wdata[1:0] == twt_pkg::CMD_RESP));
	assign trig      = holding && (data_acc || cmd_valid);
	// a choice written beside the command takes effect at once
	assign eff_ack   = wr_ctrl_b ? req.wdata[twt_pkg::CB_ACK]
		: ack_choice_ff;
	assign evt_clr   = data_acc || cmd_valid;
	// a start or stop after the first clock of a byte breaks the protocol
	assign mid_byte  = (state_ff != twt_pkg::LS_IDLE)
		&& (state_ff != twt_pkg::LS_HOLD) && (bitcnt_ff != 4'h0);

	// address match on the received byte, r/w bit in bit 0
	always_comb
	begin
		logic [6:0] a;
		logic       gcall;
		logic       own_hit;
		logic       sec_hit;
		own_hit = 1'b0;
		sec_hit = 1'b0;
		a       = shift_ff[7:1];
		gcall   = (a == 7'h00) && own_ff[0];
		if (second_ff[0])
		begin
			own_hit = (a == own_ff[7:1]);
			sec_hit = (a == second_ff[7:1]);
		end
		else
		begin
			// masked bits always compare equal
			own_hit = (((a ^ own_ff[7:1]) & ~second_ff[7:1]) == 7'h00);
			sec_hit = 1'b0;
		end
		// ten-bit first byte 11110aa is just another seven-bit pattern
		addr_hit = ctrl_a_ff[twt_pkg::CA_PROMISC] || gcall || own_hit
			|| sec_hit;
	end

	// link state machine: one step per synchronised scl edge or condition
	always_comb
	begin
		nxt_state    = state_ff;
		nxt_post     = post_ff;
		nxt_bitcnt   = bitcnt_ff;
		nxt_shift    = shift_ff;
		nxt_ack_sent = ack_sent_ff;
		set_data     = 1'b0;
		set_match    = 1'b0;
		set_cause    = 1'b0;
		set_clash    = 1'b0;
		set_fault    = 1'b0;
		set_dir      = 1'b0;
		set_rxack    = 1'b0;
		if (!ctrl_a_ff[twt_pkg::CA_ENABLE])
		begin
			nxt_state  = twt_pkg::LS_IDLE;
			nxt_bitcnt = twt_pkg::BIT_ZERO;
		end
		else if (start_det)
		begin
			set_fault  = mid_byte;
			nxt_state  = twt_pkg::LS_ADDR;
			nxt_bitcnt = twt_pkg::BIT_ZERO;
		end
		else if (stop_det)
		begin
			// start then stop with no bit between is also illegal
			set_fault  = mid_byte || ((state_ff == twt_pkg::LS_ADDR)
				&& (bitcnt_ff == twt_pkg::BIT_ZERO));
			set_match  = ctrl_a_ff[twt_pkg::CA_STOP_EN];
			set_cause  = 1'b0;
			nxt_state  = twt_pkg::LS_IDLE;
			nxt_bitcnt = twt_pkg::BIT_ZERO;
		end
		else
		begin
			case (state_ff)
				twt_pkg::LS_IDLE:
				begin
					nxt_bitcnt = twt_pkg::BIT_ZERO;
				end
				twt_pkg::LS_ADDR, twt_pkg::LS_RX:
				begin
					if (scl_rise && !holding)
					begin
						nxt_shift  = {shift_ff[6:0], sda_s_ff};
						nxt_bitcnt = bitcnt_ff + twt_pkg::BIT_ONE;
					end
					else if (scl_fall
						&& (bitcnt_ff == twt_pkg::BITS_PER_BYTE))
					begin
						nxt_bitcnt = twt_pkg::BIT_ZERO;
						if (state_ff == twt_pkg::LS_RX)
						begin
							set_data  = 1'b1;
							nxt_state = twt_pkg::LS_HOLD;
							nxt_post  = twt_pkg::PA_DATA_EVT;
						end
						else if (addr_hit)
						begin
							set_match = 1'b1;
							set_cause = 1'b1;
							set_dir   = 1'b1;
							nxt_state = twt_pkg::LS_HOLD;
							nxt_post  = twt_pkg::PA_RX;
						end
						else
						begin
							nxt_state = twt_pkg::LS_IDLE;
						end
					end
				end
				twt_pkg::LS_TX:
				begin
					if (scl_rise)
					begin
						set_clash  = shift_ff[7] && !sda_s_ff;
						nxt_bitcnt = bitcnt_ff + twt_pkg::BIT_ONE;
					end
					else if (scl_fall && (bitcnt_ff != twt_pkg::BIT_ZERO))
					begin
						if (bitcnt_ff == twt_pkg::BITS_PER_BYTE)
						begin
							nxt_state  = twt_pkg::LS_ACK_IN;
							nxt_bitcnt = twt_pkg::BIT_ZERO;
						end
						else
						begin
							nxt_shift = {shift_ff[6:0], 1'b0};
						end
					end
				end
				twt_pkg::LS_ACK_IN:
				begin
					if (scl_rise)
					begin
						set_rxack  = 1'b1;
						nxt_bitcnt = bitcnt_ff + twt_pkg::BIT_ONE;
					end
					else if (scl_fall && (bitcnt_ff != twt_pkg::BIT_ZERO))
					begin
						set_data   = 1'b1;
						nxt_state  = twt_pkg::LS_HOLD;
						nxt_post   = twt_pkg::PA_DATA_EVT;
						nxt_bitcnt = twt_pkg::BIT_ZERO;
					end
				end
				twt_pkg::LS_ACK_OUT:
				begin
					if (scl_rise)
					begin
						// match flag was cleared by the trigger before an address nack clashes
						set_clash  = ack_sent_ff && !sda_s_ff;
						nxt_bitcnt = bitcnt_ff + twt_pkg::BIT_ONE;
					end
					else if (scl_fall && (bitcnt_ff != twt_pkg::BIT_ZERO))
					begin
						nxt_bitcnt = twt_pkg::BIT_ZERO;
						case (post_ff)
							twt_pkg::PA_RX:
								nxt_state = twt_pkg::LS_RX;
							twt_pkg::PA_DATA_EVT:
							begin
								set_data  = 1'b1;
								nxt_state = twt_pkg::LS_HOLD;
							end
							default:
								nxt_state = twt_pkg::LS_IDLE;
						endcase
					end
				end
				twt_pkg::LS_HOLD:
				begin
					if (req.wr && data_acc)
					begin
						nxt_shift = req.wdata;
					end
					if (trig && wr_ctrl_b
						&& (req.wdata[1:0] == twt_pkg::CMD_COMP))
					begin
						nxt_ack_sent = eff_ack;
						nxt_post     = twt_pkg::PA_IDLE;
						nxt_state    = dir_ff ? twt_pkg::LS_IDLE
							: twt_pkg::LS_ACK_OUT;
					end
					else if (trig)
					begin
						nxt_ack_sent = eff_ack;
						if (dir_ff && (post_ff == twt_pkg::PA_DATA_EVT))
						begin
							nxt_state = twt_pkg::LS_TX;
						end
						else
						begin
							nxt_state = twt_pkg::LS_ACK_OUT;
							if (eff_ack)
								nxt_post = twt_pkg::PA_IDLE;
							else if (dir_ff)
								nxt_post = twt_pkg::PA_DATA_EVT;
							else
								nxt_post = twt_pkg::PA_RX;
						end
					end
				end
				default:
				begin
					nxt_state  = twt_pkg::LS_IDLE;
					nxt_bitcnt = twt_pkg::BIT_ZERO;
				end
			endcase
		end
	end

	// link state registers; shift writes only land while held
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_ff    <= twt_pkg::LS_IDLE;
			post_ff     <= twt_pkg::PA_IDLE;
			bitcnt_ff   <= twt_pkg::BIT_ZERO;
			shift_ff    <= twt_pkg::RST_BYTE;
			ack_sent_ff <= 1'b0;
		end
		else
		begin
			state_ff    <= nxt_state;
			post_ff     <= nxt_post;
			bitcnt_ff   <= nxt_bitcnt;
			shift_ff    <= nxt_shift;
			ack_sent_ff <= nxt_ack_sent;
		end
	end

	// pin drive; a set clash stops every sda low drive until cleared
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sda_oe_ff <= 1'b0;
			scl_oe_ff <= 1'b0;
		end
		else
		begin
			sda_oe_ff <= !(clash_ff || set_clash)
				&& (((nxt_state == twt_pkg::LS_TX) && !nxt_shift[7])
				|| ((nxt_state == twt_pkg::LS_ACK_OUT)
				&& !nxt_ack_sent));
			scl_oe_ff <= (nxt_state == twt_pkg::LS_HOLD);
		end
	end

	// software registers
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctrl_a_ff     <= twt_pkg::RST_BYTE;
			ack_choice_ff <= 1'b0;
			own_ff        <= twt_pkg::RST_BYTE;
			second_ff     <= twt_pkg::RST_BYTE;
		end
		else if (req.wr)
		begin
			if (req.addr == twt_pkg::OFF_CTRL_A)
				ctrl_a_ff <= req.wdata;
			if (wr_ctrl_b)
				ack_choice_ff <= req.wdata[twt_pkg::CB_ACK];
			if (req.addr == twt_pkg::OFF_OWN)
				own_ff <= req.wdata;
			if (req.addr == twt_pkg::OFF_SECOND)
				second_ff <= req.wdata;
		end
	end

	// event flags: a hardware set always beats a clear in the same cycle
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			data_ff  <= 1'b0;
			match_ff <= 1'b0;
			cause_ff <= 1'b0;
		end
		else
		begin
			data_ff  <= set_data || (data_ff && !evt_clr
				&& !(wr_status && req.wdata[twt_pkg::ST_DATA]));
			match_ff <= set_match || (match_ff && !evt_clr
				&& !(wr_status && req.wdata[twt_pkg::ST_MATCH]));
			if (set_match)
				cause_ff <= set_cause;
		end
	end

	// error flags; fault detection lives on the controller enable
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			clash_ff <= 1'b0;
			fault_ff <= 1'b0;
		end
		else
		begin
			clash_ff <= set_clash || (clash_ff && !start_det
				&& !(wr_status && req.wdata[twt_pkg::ST_CLASH]));
			fault_ff <= (set_fault && ctrl_a_enable) || (fault_ff
				&& !(wr_status && req.wdata[twt_pkg::ST_FAULT]));
		end
	end

	// direction and received acknowledge
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			dir_ff   <= 1'b0;
			rxack_ff <= 1'b0;
		end
		else
		begin
			if (set_dir)
				dir_ff <= shift_ff[0];
			if (set_rxack)
				rxack_ff <= sda_s_ff;
		end
	end

	// read data, one cycle after the strobe; data reads 0 unless held
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			rdata_ff <= twt_pkg::RST_BYTE;
		else if (req.rd)
		begin
			case (req.addr)
				twt_pkg::OFF_CTRL_A: rdata_ff <= ctrl_a_ff;
				twt_pkg::OFF_CTRL_B:
					rdata_ff <= {5'h00, ack_choice_ff, 2'h0};
				twt_pkg::OFF_STATUS:
					rdata_ff <= {data_ff, match_ff, scl_oe_ff, rxack_ff,
						clash_ff, fault_ff, dir_ff, cause_ff};
				twt_pkg::OFF_OWN:    rdata_ff <= own_ff;
				twt_pkg::OFF_DATA:
					rdata_ff <= holding ? shift_ff
						: twt_pkg::RST_BYTE;
				twt_pkg::OFF_SECOND: rdata_ff <= second_ff;
				default:             rdata_ff <= twt_pkg::RST_BYTE;
			endcase
		end
		else
			rdata_ff <= twt_pkg::RST_BYTE;
	end

	// outputs
	assign rdata              = rdata_ff;
	assign scl_out            = 1'b0;
	assign scl_oe             = scl_oe_ff;
	assign sda_out            = 1'b0;
	assign sda_oe             = sda_oe_ff;
	assign data_done_flag     = data_ff;
	assign match_or_halt_flag = match_ff;
	assign scl_stretch_status = scl_oe_ff;

endmodule : twt_target

// file: tb/test_two_wire_target_match_status.sv
// test_two_wire_target_match_status: self-checking bench of twt_target
// assumes: controller model on the far side, pull-ups on both wires
`timescale 1ns/1ns
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin fail_count++; \
	$display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end
module test_two_wire_target_match_status;
	logic              core_clk;
	logic              rst_n;
	twt_pkg::twt_req_s req;
	logic [7:0]        rdata;
	logic              ctrl_a_enable;
	logic              scl_out, scl_oe, sda_out, sda_oe, m_scl_oe, m_sda_oe;
	logic              done, match, held, a;
	logic [7:0]        s, rx;
	int                fail_count = 0;
	int                cmp_count = 0;
	// open-drain wires with pull-ups
	wire scl = !(scl_oe || m_scl_oe);
	wire sda = !(sda_oe || m_sda_oe);

	twt_target i_dut (.core_clk(core_clk), .rst_n(rst_n), .req(req),
		.rdata(rdata), .ctrl_a_enable(ctrl_a_enable), .scl_in(scl),
		.scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda),
		.sda_out(sda_out), .sda_oe(sda_oe), .data_done_flag(done),
		.match_or_halt_flag(match), .scl_stretch_status(held));
	twt_ctl_model i_ctl (.core_clk(core_clk), .scl(scl), .sda(sda),
		.scl_oe(m_scl_oe), .sda_oe(m_sda_oe));

	// 25 MHz core clock
	initial
	begin
		core_clk = 1'b0;
		forever #20 core_clk = !core_clk;
	end
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : test_done
	// register port: strobes last one cycle, read data in the next
	task automatic bus_wr(input logic [7:0] ad, input logic [7:0] d);
		req <= '{ad, d, 1'b1, 1'b0};
		@(posedge core_clk);
		req <= '0;
		#1;
	endtask : bus_wr
	task automatic bus_rd(input logic [7:0] ad, output logic [7:0] d);
		req <= '{ad, 8'h00, 1'b0, 1'b1};
		@(posedge core_clk);
		req <= '0;
		#1;
		d = rdata;
	endtask : bus_rd
	task automatic cfg(input logic [7:0] o, input logic [7:0] m,
		input logic [7:0] c);
		bus_wr(twt_pkg::OFF_OWN, o);
		bus_wr(twt_pkg::OFF_SECOND, m);
		bus_wr(twt_pkg::OFF_CTRL_A, c);
	endtask : cfg
	// reset values over the whole map, read back, refused data access
	task automatic t_regs();
		for (int o = 9; o < 16; o++)
		begin
			bus_rd(8'(o), s);
			`CHK(s, twt_pkg::RST_BYTE)
		end
		bus_wr(twt_pkg::OFF_SECOND, 8'h91);
		bus_rd(twt_pkg::OFF_SECOND, s);
		`CHK(s, 8'h91)
		bus_wr(twt_pkg::OFF_CTRL_B, 8'h07);
		bus_rd(twt_pkg::OFF_CTRL_B, s);
		`CHK(s, 8'h04)
		bus_wr(twt_pkg::OFF_DATA, 8'h33);
		bus_rd(twt_pkg::OFF_DATA, s);
		`CHK(s, 8'h00)
		$display("t_regs done");
	endtask : t_regs
	// match table: own, second, ctrl a, address byte, hit
	task automatic t_match();
		logic [39:0] tab [10] = '{40'h84_0001_8401, 40'h84_0001_8600,
			40'h84_0201_8601, 40'h84_9101_9001, 40'h84_9101_8401,
			40'h85_0001_0001, 40'h84_0001_0000, 40'h84_0005_5a01,
			40'hf2_0001_f201, 40'h84_0001_f200};
		foreach (tab[i])
		begin
			cfg(tab[i][39:32], tab[i][31:24], tab[i][23:16]);
			i_ctl.start();
			i_ctl.byte_io(tab[i][15:8], rx);
			`CHK(match, tab[i][0])
			`CHK(held, tab[i][0])
			if (tab[i][0])
			begin
				bus_rd(twt_pkg::OFF_STATUS, s);
				`CHK(s & 8'h03, 8'h01)
				bus_wr(twt_pkg::OFF_CTRL_B, {6'h00, twt_pkg::CMD_COMP});
			end
			i_ctl.bit_io(1'b1, a);
			`CHK(a, !tab[i][0])
			i_ctl.stop();
		end
		$display("t_match done");
	endtask : t_match
	// write transfer: data reads trigger ack, then nack
	task automatic t_write();
		cfg(8'h84, 8'h00, 8'h01);
		bus_wr(twt_pkg::OFF_CTRL_B, 8'h00);
		i_ctl.start();
		i_ctl.byte_io(8'h84, rx);
		bus_rd(twt_pkg::OFF_DATA, s);
		`CHK({held, match}, 2'b00)
		i_ctl.bit_io(1'b1, a);
		`CHK(a, 1'b0)
		i_ctl.byte_io(8'ha5, rx);
		`CHK({done, held}, 2'b11)
		bus_rd(twt_pkg::OFF_DATA, s);
		`CHK(s, 8'ha5)
		i_ctl.bit_io(1'b1, a);
		`CHK(a, 1'b0)
		i_ctl.byte_io(8'h3d, rx);
		bus_wr(twt_pkg::OFF_CTRL_B, 8'h04);
		bus_rd(twt_pkg::OFF_DATA, s);
		`CHK(s, 8'h3d)
		i_ctl.bit_io(1'b1, a);
		`CHK(a, 1'b1)
		i_ctl.stop();
		$display("t_write done");
	endtask : t_write
	// read transfer with a data clash on the first bit
	task automatic t_read();
		i_ctl.start();
		i_ctl.byte_io(8'h85, rx);
		bus_rd(twt_pkg::OFF_STATUS, s);
		`CHK(s & 8'h03, 8'h03)
		bus_wr(twt_pkg::OFF_CTRL_B, {6'h00, twt_pkg::CMD_RESP});
		i_ctl.bit_io(1'b1, a);
		`CHK({a, done, held}, 3'b011)
		bus_wr(twt_pkg::OFF_DATA, 8'h80);
		i_ctl.byte_io(8'h7f, rx);
		`CHK(rx, 8'h7f)
		i_ctl.bit_io(1'b0, a);
		`CHK(done, 1'b1)
		bus_rd(twt_pkg::OFF_STATUS, s);
		`CHK(s & 8'h98, 8'h88)
		bus_wr(twt_pkg::OFF_STATUS, 8'h08);
		bus_rd(twt_pkg::OFF_STATUS, s);
		`CHK(s[3], 1'b0)
		bus_wr(twt_pkg::OFF_CTRL_B, {6'h00, twt_pkg::CMD_COMP});
		i_ctl.stop();
		$display("t_read done");
	endtask : t_read
	// nack after address meets a low line; repeated start clears clash
	task automatic t_nack();
		i_ctl.start();
		i_ctl.byte_io(8'h84, rx);
		`CHK(match, 1'b1)
		bus_wr(twt_pkg::OFF_CTRL_B, {6'h01, twt_pkg::CMD_RESP});
		i_ctl.bit_io(1'b0, a);
		bus_rd(twt_pkg::OFF_STATUS, s);
		`CHK(s[3], 1'b1)
		i_ctl.start();
		bus_rd(twt_pkg::OFF_STATUS, s);
		`CHK(s[3], 1'b0)
		i_ctl.byte_io(8'h10, rx);
		i_ctl.bit_io(1'b1, a);
		i_ctl.stop();
		$display("t_nack done");
	endtask : t_nack
	// stop events enabled: a stop raises the match flag with cause 0
	task automatic t_stop();
		bus_wr(twt_pkg::OFF_CTRL_A, 8'h21);
		i_ctl.start();
		i_ctl.byte_io(8'h10, rx);
		i_ctl.bit_io(1'b1, a);
		i_ctl.stop();
		bus_rd(twt_pkg::OFF_STATUS, s);
		`CHK(s & 8'h61, 8'h40)
		bus_wr(twt_pkg::OFF_STATUS, 8'h40);
		bus_wr(twt_pkg::OFF_CTRL_A, 8'h01);
		`CHK(match, 1'b0)
		$display("t_stop done");
	endtask : t_stop
	// start straight into stop, with and without controller enable
	task automatic t_fault();
		for (int e = 1; e >= 0; e--)
		begin
			ctrl_a_enable <= e[0];
			i_ctl.start();
			i_ctl.stop();
			bus_rd(twt_pkg::OFF_STATUS, s);
			`CHK(s[2], e[0])
			bus_wr(twt_pkg::OFF_STATUS, 8'h04);
			bus_rd(twt_pkg::OFF_STATUS, s);
			`CHK(s[2], 1'b0)
		end
		$display("t_fault done");
	endtask : t_fault
	// hang guard, far above the whole run
	initial
	begin
		repeat (90000) @(posedge core_clk);
		fail_count++;
		test_done();
	end
	// reset for three cycles, then the scenarios
	initial
	begin
		rst_n = 1'b0;
		req = '0;
		ctrl_a_enable = 1'b1;
		repeat (3) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		#1;
		t_regs();
		t_match();
		t_write();
		t_read();
		t_nack();
		t_stop();
		t_fault();
		`CHK(i_ctl.hang, 0)
		test_done();
	end
endmodule : test_two_wire_target_match_status

// file: tb/twt_ctl_model.sv
// twt_ctl_model: behavioural two-wire bus controller
// assumes: bench resolves both wires with pull-ups, shares the core clock
`timescale 1ns/1ns
module twt_ctl_model
#(
	parameter int HALF = 10 // scl low 2x HALF, high about HALF: period near 31 core clocks, above 4x
)
(
	// clock
	input wire logic core_clk,
	// resolved wires
	input wire logic scl,
	input wire logic sda,
	// pull-down enables
	output logic     scl_oe,
	output logic     sda_oe
);
	int hang = 0;
	// bus idle at time zero, scl stands still between frames
	initial
	begin
		scl_oe = 1'b0;
		sda_oe = 1'b0;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge core_clk);
	endtask : wt
	// release scl, honour clock stretching with a bounded wait
	task automatic rise();
		scl_oe <= 1'b0;
		for (int i = 0; i < 600 && scl !== 1'b1; i++)
			@(posedge core_clk);
		if (scl !== 1'b1)
			hang++;
		wt(HALF);
	endtask : rise
	// start or repeated start: sda falls while scl high
	task automatic start();
		sda_oe <= 1'b0;
		wt(HALF);
		rise();
		sda_oe <= 1'b1;
		wt(HALF);
		scl_oe <= 1'b1;
		wt(HALF);
	endtask : start
	// stop: sda rises while scl high
	task automatic stop();
		sda_oe <= 1'b1;
		wt(HALF);
		rise();
		sda_oe <= 1'b0;
		wt(HALF);
	endtask : stop
	// one bit, sda changed only while scl low; r sampled late in high
	task automatic bit_io(input logic b, output logic r);
		sda_oe <= !b;
		wt(HALF);
		rise();
		r = sda;
		scl_oe <= 1'b1;
		wt(HALF);
	endtask : bit_io
	// eight bits, most significant first
	task automatic byte_io(input logic [7:0] v, output logic [7:0] r);
		for (int i = 7; i >= 0; i--)
			bit_io(v[i], r[i]);
	endtask : byte_io
endmodule : twt_ctl_model

// file: tb/twt_target_assertions.sv
// twt_chk: port-level checks of the two-wire target
// assumes: bound to twt_target, single core clock domain
`timescale 1ns/1ns
module twt_chk
(
	// clock and reset
	input wire logic              core_clk,
	input wire logic              rst_n,
	// register port
	input wire twt_pkg::twt_req_s req,
	input wire logic [7:0]        rdata,
	// pins and flags
	input wire logic              scl_out,
	input wire logic              scl_oe,
	input wire logic              sda_out,
	input wire logic              sda_oe,
	input wire logic              data_done_flag,
	input wire logic              match_or_halt_flag,
	input wire logic              scl_stretch_status
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// data access and command strobes seen at the port
	wire data_acc = (req.rd || req.wr) && req.addr == twt_pkg::OFF_DATA;
	wire cmd_wr   = req.wr && req.addr == twt_pkg::OFF_CTRL_B && req.wdata[1];

	stretch_mirror_a: assert property (scl_stretch_status == scl_oe)
		else $error("stretch status differs from scl hold");
	open_drain_a: assert property (!scl_out && !sda_out)
		else $error("pin driven high");
	read_idle_a: assert property (!$past(req.rd) |-> rdata == 8'h00)
		else $error("read data outside answer cycle");
	hold_cause_a: assert property (scl_oe |-> data_done_flag ||
		match_or_halt_flag)
		else $error("scl held without pending event");
	hold_start_a: assert property ($rose(scl_oe) |->
		data_done_flag || match_or_halt_flag)
		else $error("scl hold began without event");
	data_hold_a: assert property ($rose(data_done_flag) |=> scl_oe)
		else $error("data event did not hold scl");
	data_trig_a: assert property (scl_oe && data_acc |=> !scl_oe &&
		!data_done_flag && !match_or_halt_flag)
		else $error("held data access did not release");
	cmd_trig_a: assert property (scl_oe && cmd_wr |=> !scl_oe &&
		!data_done_flag && !match_or_halt_flag)
		else $error("command did not release hold");
	refuse_read_a: assert property (req.rd && req.addr ==
		twt_pkg::OFF_DATA && !scl_oe |=> rdata == 8'h00)
		else $error("data read outside hold returned data");
	reset_clear_a: assert property (!$past(rst_n) |-> !scl_oe && !sda_oe
		&& !data_done_flag && !match_or_halt_flag)
		else $error("outputs not clear after reset");
endmodule : twt_chk

bind twt_target twt_chk i_chk (.core_clk(core_clk), .rst_n(rst_n),
	.req(req), .rdata(rdata), .scl_out(scl_out), .scl_oe(scl_oe),
	.sda_out(sda_out), .sda_oe(sda_oe), .data_done_flag(data_done_flag),
	.match_or_halt_flag(match_or_halt_flag),
	.scl_stretch_status(scl_stretch_status));
